// ===== hw/codec_serial_defs.vh
// Register offsets, field positions, reset values and timing counts for the
// serial-interface control and status register group.
// Assumes a host register port with 7-bit page-0 addresses and 8-bit data.
//
// Operation
// - Format field selects I2S, DSP, right, left justified.
// - Word length codes give 16, 20, 24, 32 bits.
// - Rate bit matters only when bit clock output.
// - Rate bit one gives 256 clocks per frame.
// - DAC re-sync realigns on quarter-period group-delay drift.
// - ADC re-sync realigns on quarter-period group-delay drift.
// - Mute bit chooses direct or soft-muted realignment.
// - Offset field delays data 0 to 255 bit clocks.
// - DSP offset counts from word clock rising edge.
// - Four overflow flags latch and stay set.
// - Reading flag register clears the flags.
// - PLL R field: 1 to 15, zero means 16.
// - ADC high-pass codes: off or three corners.
// - Per-channel DAC effects filter enable bits.
// - Per-channel DAC de-emphasis filter enable bits.
// - Direction bit makes bit clock input or output.
`ifndef CODEC_SERIAL_DEFS_VH
`define CODEC_SERIAL_DEFS_VH

// Register offsets.
`define OFS_IFACE_A 7'h08
`define OFS_FORMAT 7'h09
`define OFS_SLOT 7'h0A
`define OFS_FLAGS 7'h0B
`define OFS_FILTER 7'h0C

// Reset values.
`define RST_FORMAT 8'h00
`define RST_SLOT 8'h00
`define RST_PLL_R 4'h1
`define RST_FILTER 8'h00
`define RST_IFACE_A 8'h00

// Field positions.
`define BIT_BCLK_DIR 7
`define BIT_WCLK_DIR 6
`define BIT_RATE256 3
`define BIT_DAC_RESYNC 2
`define BIT_ADC_RESYNC 1
`define BIT_RESYNC_MUTE 0

// Transfer formats.
`define FMT_I2S 2'h0
`define FMT_DSP 2'h1
`define FMT_RIGHT 2'h2
`define FMT_LEFT 2'h3

// Frame length in 256-clock mode and bit clock divider default.
`define FRAME_256 9'h100
`define BCLK_HALF_DIV 8'h04

`endif

// ===== hw/bclk_frame_gen.v
// Bit clock and word clock generator for master mode.
// Assumes one core clock; emits the serial clocks as pin outputs and a
// one-cycle bit enable, and reports the bit position within the frame.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_defs.vh"

module bclk_frame_gen #(
  parameter [7:0] HALF_DIV = `BCLK_HALF_DIV
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire run,
  input wire [8:0] frame_len,
  output reg bclk_out_r,
  output reg wclk_out_r,
  output reg bit_en_r,
  output reg [8:0] bit_pos_r
);

  // Counts core cycles within one half bit clock period.
  reg [7:0] div_r;

  // Divides the core clock, toggles the bit clock and walks the frame.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 8'h00;
      bclk_out_r <= 1'b0;
      wclk_out_r <= 1'b0;
      bit_en_r <= 1'b0;
      bit_pos_r <= 9'h000;
    end else if (!run) begin
      // Clocks rest low while the generator is stopped.
      div_r <= 8'h00;
      bclk_out_r <= 1'b0;
      wclk_out_r <= 1'b0;
      bit_en_r <= 1'b0;
      bit_pos_r <= 9'h000;
    end else if (div_r == HALF_DIV - 8'h01) begin
      div_r <= 8'h00;
      bclk_out_r <= ~bclk_out_r;
      // A bit begins on each rising bit clock edge.
      bit_en_r <= ~bclk_out_r;
      if (!bclk_out_r) begin
        if (bit_pos_r >= frame_len - 9'h001) begin
          bit_pos_r <= 9'h000;
          wclk_out_r <= 1'b1;
        end else begin
          bit_pos_r <= bit_pos_r + 9'h001;
          // Word clock is high for the first half of the frame.
          wclk_out_r <= (bit_pos_r + 9'h001) < {1'b0, frame_len[8:1]};
        end
      end
    end else begin
      div_r <= div_r + 8'h01;
      bit_en_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== hw/codec_serial_filter_ctrl_regs.v
// Control and status registers of the audio serial interface, overflow
// flags, PLL R divider and digital filter enables.
// Assumes a synchronous host register port on ref_clk (address, write and
// read strobes) and overflow pulses and serial pins from the data path.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_defs.vh"

module codec_serial_filter_ctrl_regs #(
  parameter [7:0] HALF_DIV = `BCLK_HALF_DIV
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output reg reg_rvalid_r,
  input wire ovf_adc_left,
  input wire ovf_adc_right,
  input wire ovf_dac_left,
  input wire ovf_dac_right,
  input wire [7:0] adc_delay_drift,
  input wire [7:0] dac_delay_drift,
  input wire [7:0] adc_quarter_period,
  input wire [7:0] dac_quarter_period,
  input wire bclk_in,
  input wire wclk_in,
  output wire bclk_o,
  output wire bclk_oe,
  output wire wclk_o,
  output wire wclk_oe,
  output reg [1:0] xfer_format_r,
  output reg i2s_format_r,
  output reg dsp_format_r,
  output reg right_justified_format_r,
  output reg left_justified_format_r,
  output reg [5:0] word_bits_r,
  output reg [8:0] frame_bclks_r,
  output reg [7:0] slot_offset_r,
  output reg slot_start_r,
  output reg adc_realign_r,
  output reg dac_realign_r,
  output reg adc_soft_mute_r,
  output reg dac_soft_mute_r,
  output reg [4:0] pll_r_div_r,
  output reg [1:0] hpf_left_r,
  output reg [1:0] hpf_right_r,
  output reg dac_left_effects_en_r,
  output reg dac_left_deemph_en_r,
  output reg dac_right_effects_en_r,
  output reg dac_right_deemph_en_r
);

  // Maps a word length code to the sample width in bits.
  function [5:0] word_width;
    input [1:0] code;
    begin
      case (code)
        2'h0: word_width = 6'h10;
        2'h1: word_width = 6'h14;
        2'h2: word_width = 6'h18;
        default: word_width = 6'h20;
      endcase
    end
  endfunction

  // Reports a group-delay drift beyond the quarter sample period.
  function drift_exceeds;
    input [7:0] drift;
    input [7:0] quarter;
    begin
      drift_exceeds = drift > quarter;
    end
  endfunction

  // Interface control A (direction bits) and the format register.
  reg [7:0] iface_a_r;
  reg [7:0] format_r;
  // Stored filter control byte.
  reg [7:0] filter_r;
  // Stored PLL R code.
  reg [3:0] pll_r_code_r;
  // Sticky overflow flags, left ADC in bit 3 down to right DAC in bit 0.
  reg [3:0] ovf_r;
  // Synchronisers for the incoming serial clocks.
  reg bclk_s1_r;
  reg bclk_s2_r;
  reg bclk_s3_r;
  reg wclk_s1_r;
  reg wclk_s2_r;
  reg wclk_s3_r;
  // Slave-mode bit counter since the frame start.
  reg [8:0] slave_pos_r;
  // Realignment hold state per converter.
  reg adc_pending_r;
  reg dac_pending_r;

  // Decoded control fields.
  wire master_bclk = iface_a_r[`BIT_BCLK_DIR];
  wire master_wclk = iface_a_r[`BIT_WCLK_DIR];
  wire rate256 = format_r[`BIT_RATE256];
  wire [1:0] wl_code = format_r[5:4];
  wire [5:0] width_now = word_width(wl_code);
  // Continuous-transfer frame is two words back to back.
  wire [8:0] cont_len = {2'b00, width_now, 1'b0};
  // The rate bit is only honoured while the bit clock is generated here.
  wire [8:0] gen_len = (master_bclk && rate256) ? `FRAME_256 : cont_len;

  // Outputs of the master clock generator.
  wire gen_bclk;
  wire gen_wclk;
  wire gen_bit_en;
  wire [8:0] gen_pos;

  bclk_frame_gen #(
    .HALF_DIV(HALF_DIV)
  ) u_gen (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(master_bclk),
    .frame_len(gen_len),
    .bclk_out_r(gen_bclk),
    .wclk_out_r(gen_wclk),
    .bit_en_r(gen_bit_en),
    .bit_pos_r(gen_pos)
  );

  // Pin drivers: output enables high only in master operation.
  assign bclk_o = gen_bclk;
  assign bclk_oe = master_bclk;
  assign wclk_o = gen_wclk;
  assign wclk_oe = master_wclk;

  // Brings the external clocks into the core domain.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
      wclk_s1_r <= 1'b0;
      wclk_s2_r <= 1'b0;
      wclk_s3_r <= 1'b0;
    end else begin
      bclk_s1_r <= bclk_in;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
      wclk_s1_r <= wclk_in;
      wclk_s2_r <= wclk_s1_r;
      wclk_s3_r <= wclk_s2_r;
    end
  end

  // Bit and word clock views chosen by direction.
  wire bit_edge = master_bclk ? gen_bit_en : (bclk_s2_r & ~bclk_s3_r);
  wire wclk_now = master_wclk ? gen_wclk : wclk_s2_r;
  wire wclk_prev = master_wclk ? gen_wclk : wclk_s3_r;
  // Frame start: word clock rising for DSP, otherwise any word clock edge
  // that opens the left word (falling for I2S, rising for justified modes).
  wire wclk_rise = wclk_now & ~wclk_prev;
  wire wclk_fall = ~wclk_now & wclk_prev;
  wire frame_start_slave = (format_r[7:6] == `FMT_I2S) ? wclk_fall : wclk_rise;

  // Counts bit clocks since the frame start in slave operation.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slave_pos_r <= 9'h000;
    end else if (frame_start_slave) begin
      slave_pos_r <= 9'h000;
    end else if (bit_edge && slave_pos_r != 9'h1FF) begin
      slave_pos_r <= slave_pos_r + 9'h001;
    end
  end

  // Current bit position in the frame from whichever clock source is live.
  wire [8:0] cur_pos = master_bclk ? gen_pos : slave_pos_r;

  // Marks the bit clock at which the data slot begins.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_start_r <= 1'b0;
    end else begin
      slot_start_r <= bit_edge && (cur_pos == {1'b0, slot_offset_r});
    end
  end

  // Flag register read: clear only what was reported.
  wire flags_read = reg_rd && (reg_addr == `OFS_FLAGS);
  wire [3:0] ovf_in = {ovf_adc_left, ovf_adc_right, ovf_dac_left, ovf_dac_right};

  // Sticky overflow flags; a new event in the read cycle wins over the clear.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_r <= 4'h0;
    end else if (flags_read) begin
      ovf_r <= ovf_in;
    end else begin
      ovf_r <= ovf_r | ovf_in;
    end
  end

  // Register writes from the host.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      iface_a_r <= `RST_IFACE_A;
      format_r <= `RST_FORMAT;
      slot_offset_r <= `RST_SLOT;
      pll_r_code_r <= `RST_PLL_R;
      filter_r <= `RST_FILTER;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_IFACE_A: begin
          iface_a_r <= reg_wdata;
        end
        `OFS_FORMAT: begin
          format_r <= reg_wdata;
        end
        `OFS_SLOT: begin
          // Range limits per rate mode are the host's to respect.
          slot_offset_r <= reg_wdata;
        end
        `OFS_FLAGS: begin
          // Only the divider is writable; flag bits ignore writes.
          pll_r_code_r <= reg_wdata[3:0];
        end
        `OFS_FILTER: begin
          filter_r <= reg_wdata;
        end
        default: begin
          // Other addresses belong to other blocks.
        end
      endcase
    end
  end

  // Read data mux; unmapped addresses read as zero.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `OFS_IFACE_A: reg_rdata_r <= iface_a_r;
          `OFS_FORMAT: reg_rdata_r <= format_r;
          `OFS_SLOT: reg_rdata_r <= slot_offset_r;
          `OFS_FLAGS: reg_rdata_r <= {ovf_r, pll_r_code_r};
          `OFS_FILTER: reg_rdata_r <= filter_r;
          default: reg_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // Drift detection on each converter.
  wire adc_drift = format_r[`BIT_ADC_RESYNC] &&
    drift_exceeds(adc_delay_drift, adc_quarter_period);
  wire dac_drift = format_r[`BIT_DAC_RESYNC] &&
    drift_exceeds(dac_delay_drift, dac_quarter_period);
  wire mute_mode = format_r[`BIT_RESYNC_MUTE];

  // Frame start seen by the realignment logic in either mode.
  wire frame_start_any = master_bclk ? (gen_bit_en && gen_pos == 9'h000)
    : frame_start_slave;

  // Realignment control. Direct mode realigns at once; mute mode first
  // soft-mutes the channel and realigns on the next frame start.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_pending_r <= 1'b0;
      dac_pending_r <= 1'b0;
      adc_realign_r <= 1'b0;
      dac_realign_r <= 1'b0;
      adc_soft_mute_r <= 1'b0;
      dac_soft_mute_r <= 1'b0;
    end else begin
      adc_realign_r <= 1'b0;
      dac_realign_r <= 1'b0;
      if (adc_pending_r) begin
        if (frame_start_any) begin
          adc_realign_r <= 1'b1;
          adc_pending_r <= 1'b0;
          adc_soft_mute_r <= 1'b0;
        end
      end else if (adc_drift) begin
        if (mute_mode) begin
          adc_pending_r <= 1'b1;
          adc_soft_mute_r <= 1'b1;
        end else begin
          adc_realign_r <= 1'b1;
        end
      end
      if (dac_pending_r) begin
        if (frame_start_any) begin
          dac_realign_r <= 1'b1;
          dac_pending_r <= 1'b0;
          dac_soft_mute_r <= 1'b0;
        end
      end else if (dac_drift) begin
        if (mute_mode) begin
          dac_pending_r <= 1'b1;
          dac_soft_mute_r <= 1'b1;
        end else begin
          dac_realign_r <= 1'b1;
        end
      end
    end
  end

  // Decoded control outputs, registered.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xfer_format_r <= `FMT_I2S;
      i2s_format_r <= 1'b1;
      dsp_format_r <= 1'b0;
      right_justified_format_r <= 1'b0;
      left_justified_format_r <= 1'b0;
      word_bits_r <= 6'h10;
      frame_bclks_r <= 9'h020;
      pll_r_div_r <= 5'h01;
      hpf_left_r <= 2'h0;
      hpf_right_r <= 2'h0;
      dac_left_effects_en_r <= 1'b0;
      dac_left_deemph_en_r <= 1'b0;
      dac_right_effects_en_r <= 1'b0;
      dac_right_deemph_en_r <= 1'b0;
    end else begin
      xfer_format_r <= format_r[7:6];
      i2s_format_r <= format_r[7:6] == `FMT_I2S;
      dsp_format_r <= format_r[7:6] == `FMT_DSP;
      right_justified_format_r <= format_r[7:6] == `FMT_RIGHT;
      left_justified_format_r <= format_r[7:6] == `FMT_LEFT;
      word_bits_r <= width_now;
      frame_bclks_r <= gen_len;
      // Code zero stands for a divider of sixteen.
      pll_r_div_r <= (pll_r_code_r == 4'h0) ? 5'h10 : {1'b0, pll_r_code_r};
      // Zero disables; other codes pick the corner in the filter itself.
      hpf_left_r <= filter_r[7:6];
      hpf_right_r <= filter_r[5:4];
      dac_left_effects_en_r <= filter_r[3];
      dac_left_deemph_en_r <= filter_r[2];
      dac_right_effects_en_r <= filter_r[1];
      dac_right_deemph_en_r <= filter_r[0];
    end
  end

endmodule
`default_nettype wire

// ===== verification/serial_regs_asserts.sv
// Checker for the serial control register group: mirrors host writes.
// Assumes it is bound onto the register group top and sees its ports.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_defs.vh"
module serial_regs_asserts (
  input wire ref_clk,
  input wire sys_rst,
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r,
  input wire ovf_adc_left,
  input wire ovf_adc_right,
  input wire ovf_dac_left,
  input wire ovf_dac_right,
  input wire bclk_oe,
  input wire [1:0] xfer_format_r,
  input wire i2s_format_r,
  input wire dsp_format_r,
  input wire right_justified_format_r,
  input wire left_justified_format_r,
  input wire [5:0] word_bits_r,
  input wire [8:0] frame_bclks_r,
  input wire [7:0] slot_offset_r,
  input wire [4:0] pll_r_div_r
);
  reg [7:0] fmt_q, slot_q, dir_q; // Mirrors of the written registers.
  reg [3:0] pll_q, flg_q; // Mirror of divider code and sticky flags.
  reg [1:0] age; // Cycles since the last write, saturating.
  wire [3:0] ovf_v = {ovf_adc_left, ovf_adc_right, ovf_dac_left, ovf_dac_right};
  wire flag_rd = reg_rd && reg_addr == `OFS_FLAGS;
  wire settled = age == 2'h3;
  wire [5:0] wb = (fmt_q[5:4] == 2'h3) ? 6'h20 : 6'h10 + {2'h0, fmt_q[5:4], 2'h0};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Track writes and flag events; decoded outputs are judged once settled.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fmt_q <= 8'h00;
      slot_q <= 8'h00;
      dir_q <= 8'h00;
      pll_q <= 4'h1;
      flg_q <= 4'h0;
      age <= 2'h3;
    end else begin
      if (reg_wr) age <= 2'h0;
      else if (!settled) age <= age + 2'h1;
      if (reg_wr && reg_addr == `OFS_IFACE_A) dir_q <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_FORMAT) fmt_q <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_SLOT) slot_q <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_FLAGS) pll_q <= reg_wdata[3:0];
      flg_q <= (flag_rd ? 4'h0 : flg_q) | ovf_v;
    end
  end
  a_format_decode: assert property (
    settled |-> xfer_format_r == fmt_q[7:6] && {left_justified_format_r,
    right_justified_format_r, dsp_format_r, i2s_format_r} == (4'h1 << fmt_q[7:6]))
    else $error("format decode mismatch");
  a_word_length: assert property (
    settled |-> word_bits_r == wb) else $error("word length mismatch");
  a_frame_length: assert property (
    settled |-> frame_bclks_r == ((dir_q[7] && fmt_q[3]) ? 9'h100 : {2'h0, wb, 1'b0}))
    else $error("frame length mismatch");
  a_slot_offset: assert property (
    settled |-> slot_offset_r == slot_q) else $error("slot offset mismatch");
  a_pll_divider: assert property (
    settled |-> pll_r_div_r == ((pll_q == 4'h0) ? 5'h10 : {1'b0, pll_q}))
    else $error("divider mismatch");
  a_bclk_dir: assert property (
    settled |-> bclk_oe == dir_q[7]) else $error("bit clock direction mismatch");
  a_flag_sticky: assert property (
    flag_rd |=> reg_rdata_r == {$past(flg_q), $past(pll_q)})
    else $error("flag read mismatch");
  a_flag_clear: assert property (
    flag_rd && ovf_v == 4'h0 ##1 ovf_v == 4'h0 ##1 flag_rd |=> reg_rdata_r[7:4] == 4'h0)
    else $error("flags not cleared");
endmodule
bind codec_serial_filter_ctrl_regs serial_regs_asserts chk (.*);
`default_nettype wire

// ===== verification/host_model.sv
// Host controller model: register writes and reads on the register port.
// Assumes the strobes are sampled on the rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_defs.vh"
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata_r,
  input wire logic reg_rvalid_r,
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  logic [7:0] fmt_h = 8'h00; // Last format written.
  logic master_h = 1'b0; // High while the device drives the bit clock.
  // Idle port at time zero.
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write; a slot offset beyond the legal maximum is cut back to it.
  task wr(input [6:0] a, input [7:0] d);
    logic [7:0] lim;
    begin
      lim = (fmt_h[7:6] == `FMT_DSP) ? 8'h10 : 8'h11;
      if (master_h && fmt_h[3]) lim = lim + 8'hE1;
      if (a == `OFS_SLOT && d > lim) d = lim;
      if (a == `OFS_FORMAT) fmt_h = d;
      if (a == `OFS_IFACE_A) master_h = d[7];
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
    end
  endtask
  // One read; a missing answer yields unknown data.
  task rd(input [6:0] a, output [7:0] d);
    begin
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rvalid_r ? reg_rdata_r : 8'hXX;
    end
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the serial control register group.
// Assumes the host model drives the register port; events are driven here.
`timescale 1ns/10ps
`default_nettype none
`include "codec_serial_defs.vh"
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ovf_adc_left = 1'b0, ovf_adc_right = 1'b0, ovf_dac_left = 1'b0, ovf_dac_right = 1'b0;
  logic [7:0] adc_delay_drift = 8'h00, dac_delay_drift = 8'h00; // Drift inputs.
  logic [7:0] adc_quarter_period = 8'h10, dac_quarter_period = 8'h10; // Fixed limits.
  logic bclk_in = 1'b0, wclk_in = 1'b0; // Slave clocks stay idle.
  wire [6:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata_r, slot_offset_r;
  wire reg_wr, reg_rd, reg_rvalid_r, bclk_o, bclk_oe, wclk_o, wclk_oe, slot_start_r;
  wire [1:0] xfer_format_r, hpf_left_r, hpf_right_r;
  wire i2s_format_r, dsp_format_r, right_justified_format_r, left_justified_format_r;
  wire [5:0] word_bits_r;
  wire [8:0] frame_bclks_r;
  wire adc_realign_r, dac_realign_r, adc_soft_mute_r, dac_soft_mute_r;
  wire [4:0] pll_r_div_r;
  wire dac_left_effects_en_r, dac_left_deemph_en_r, dac_right_effects_en_r, dac_right_deemph_en_r;
  logic [7:0] rdat; // Last read data.
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  codec_serial_filter_ctrl_regs #(.HALF_DIV(8'h02)) dut (.*);
  host_model host (.*);
  always #5 ref_clk = ~ref_clk;
  // Cut a hang short.
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  task check(input [8:0] seen, input [8:0] want);
    begin
      n_compared = n_compared + 1;
      if (seen !== want) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Write, then let the register and its decode settle.
  task setw(input [6:0] a, input [7:0] d);
    begin
      host.wr(a, d);
      repeat (3) @(posedge ref_clk);
      #1;
    end
  endtask
  // Overflow events held for one edge.
  task pulse_ovf(input [3:0] v);
    begin
      @(posedge ref_clk);
      #1;
      {ovf_adc_left, ovf_adc_right, ovf_dac_left, ovf_dac_right} = v;
      @(posedge ref_clk);
      #1;
      {ovf_adc_left, ovf_adc_right, ovf_dac_left, ovf_dac_right} = 4'h0;
    end
  endtask
  // Reset values of all registers plus one unmapped address.
  task t_reset;
    int i;
    begin
      for (i = 0; i < 6; i++) begin
        host.rd(7'h08 + i[6:0], rdat);
        check(rdat, (i == 3) ? 8'h01 : 8'h00);
      end
      check(pll_r_div_r, 9'h001);
      $display("reset test done");
    end
  endtask
  // Every format and word length, slave and master, both rate modes.
  task t_format;
    int c;
    logic [5:0] wb;
    begin
      for (c = 0; c < 4; c++) begin
        wb = (c == 3) ? 6'h20 : 6'h10 + {2'h0, c[1:0], 2'h0};
        setw(`OFS_FORMAT, {c[1:0], c[1:0], 4'h8});
        check(xfer_format_r, c[1:0]);
        check({left_justified_format_r, right_justified_format_r, dsp_format_r,
               i2s_format_r}, 9'h001 << c);
        check(word_bits_r, wb);
        check(frame_bclks_r, {2'h0, wb, 1'b0});
        setw(`OFS_IFACE_A, 8'h80);
        check(bclk_oe, 1'b1);
        check(frame_bclks_r, 9'h100);
        setw(`OFS_FORMAT, {c[1:0], c[1:0], 4'h0});
        check(frame_bclks_r, {2'h0, wb, 1'b0});
        host.rd(`OFS_FORMAT, rdat);
        check(rdat, {c[1:0], c[1:0], 4'h0});
        setw(`OFS_IFACE_A, 8'h00);
        check(bclk_oe, 1'b0);
      end
      $display("format test done");
    end
  endtask
  // Largest legal offsets in continuous and 256-clock modes.
  task t_offset;
    begin
      setw(`OFS_FORMAT, 8'h00);
      setw(`OFS_SLOT, 8'h11);
      check(slot_offset_r, 9'h011);
      setw(`OFS_IFACE_A, 8'h80);
      setw(`OFS_FORMAT, 8'h48);
      setw(`OFS_SLOT, 8'hF1);
      check(slot_offset_r, 9'h0F1);
      host.rd(`OFS_SLOT, rdat);
      check(rdat, 8'hF1);
      setw(`OFS_IFACE_A, 8'h00);
      $display("offset test done");
    end
  endtask
  // Sticky flags, clear on read, event during a read, divider field.
  task t_flags;
    int i;
    begin
      for (i = 0; i < 4; i++) begin
        pulse_ovf(4'h8 >> i);
        host.rd(`OFS_FLAGS, rdat);
        check(rdat, {4'h8 >> i, 4'h1});
        host.rd(`OFS_FLAGS, rdat);
        check(rdat, 8'h01);
      end
      fork
        host.rd(`OFS_FLAGS, rdat);
        pulse_ovf(4'hA);
      join
      check(rdat, 8'h01);
      host.rd(`OFS_FLAGS, rdat);
      check(rdat, 8'hA1);
      setw(`OFS_FLAGS, 8'hF0);
      check(pll_r_div_r, 9'h010);
      host.rd(`OFS_FLAGS, rdat);
      check(rdat, 8'h00);
      setw(`OFS_FLAGS, 8'h0F);
      check(pll_r_div_r, 9'h00F);
      $display("flag test done");
    end
  endtask
  // All high-pass codes on both channels; each DAC bit both ways.
  task t_filter;
    int c;
    begin
      for (c = 0; c < 4; c++) begin
        setw(`OFS_FILTER, {c[1:0], ~c[1:0], 4'h5 << c[0]});
        check(hpf_left_r, c[1:0]);
        check(hpf_right_r, {~c[1:0]});
        check({dac_left_effects_en_r, dac_right_effects_en_r}, {2{c[0]}});
        check({dac_left_deemph_en_r, dac_right_deemph_en_r}, {2{~c[0]}});
      end
      $display("filter test done");
    end
  endtask
  // Drift beyond a quarter period: disabled, direct and muted realignment.
  task drift_try(input [7:0] f, output [3:0] seen);
    begin
      seen = 4'h0;
      setw(`OFS_FORMAT, f);
      adc_delay_drift = 8'h20;
      dac_delay_drift = 8'h20;
      repeat (3) begin
        @(posedge ref_clk);
        #1;
        seen = seen | {adc_realign_r, dac_realign_r, adc_soft_mute_r, dac_soft_mute_r};
      end
      adc_delay_drift = 8'h00;
      dac_delay_drift = 8'h00;
    end
  endtask
  task t_resync;
    logic [3:0] seen;
    logic [1:0] got;
    begin
      drift_try(8'h00, seen);
      check(seen, 4'h0);
      drift_try(8'h06, seen);
      check(seen, 4'hC);
      drift_try(8'h07, seen);
      check(seen[1:0], 2'h3);
      check(seen[3:2], 2'h0);
      // Idle slave clocks give no frame start; the master clocks give one.
      got = 2'h0;
      setw(`OFS_IFACE_A, 8'h80);
      repeat (300) begin
        @(posedge ref_clk);
        #1;
        got = got | {adc_realign_r, dac_realign_r};
      end
      check(got, 2'h3);
      check({adc_soft_mute_r, dac_soft_mute_r}, 2'h0);
      $display("resync test done");
    end
  endtask
  // Master framing on the pins: bit clocks between two word clock rises
  // and the bit clock at which the slot pulse appears.
  task frame_try(input [7:0] f, input [7:0] ofs, input [8:0] len);
    logic pb, pw;
    logic [8:0] n, seen_len, seen_slot;
    logic [1:0] rises;
    int i;
    begin
      setw(`OFS_IFACE_A, 8'hC0);
      setw(`OFS_FORMAT, f);
      setw(`OFS_SLOT, ofs);
      check({bclk_oe, wclk_oe}, 2'h3);
      n = 9'h000;
      seen_len = 9'h000;
      seen_slot = 9'h1FF;
      rises = 2'h0;
      pb = bclk_o;
      pw = wclk_o;
      for (i = 0; i < 2400 && rises < 2'h2; i++) begin
        @(posedge ref_clk);
        #1;
        if (bclk_o && !pb) n = n + 9'h001;
        if (slot_start_r && rises == 2'h1) seen_slot = n;
        if (wclk_o && !pw) begin
          if (rises == 2'h1) seen_len = n;
          rises = rises + 2'h1;
          n = 9'h000;
        end
        pb = bclk_o;
        pw = wclk_o;
      end
      check(seen_len, len);
      check(seen_slot, {1'b0, ofs});
    end
  endtask
  task t_frame;
    begin
      frame_try(8'hC0, 8'h11, 9'h020);
      frame_try(8'h48, 8'hF1, 9'h100);
      $display("frame test done");
    end
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_reset;
    t_format;
    t_offset;
    t_flags;
    t_filter;
    t_resync;
    t_frame;
    give_verdict;
  end
endmodule
`default_nettype wire
